//--- hdl/asq_defines.svh
// Offsets, field positions, reset values and timing counts of the simultaneous-sample sequencer.
// What this block does
// - With the arrangement bit set, convert one group A and one group B channel per pulse.
// - Software picks any matching pair from the first through the eighth and converts it.
// - A conversion starts on a PWM event, a software write or the external start pin.
// - Interrupt flags set a few system clocks after the result update, never before.
// - Both channels of the pair are captured together at the sample/hold falling edge.
// - Sample/hold width is one plus the four-bit acquisition field, in converter clocks.
// - Sampling begins two and a half converter clocks after the trigger.
// - First A result lands four converter clocks after sampling, B after five.
// - Following results arrive every three plus acquisition field converter clocks, or two plus it with the arrangement bit clear.
// - Each conversion yields a 12-bit code through an eight-stage pipeline for group A and a ten-stage one for group B.
// - With the arrangement bit clear, one selected channel converts per pulse.
`ifndef ASQ_DEFINES_SVH
`define ASQ_DEFINES_SVH

// Clock rates and converter timing.
`define ASQ_CLK_PERIOD_NS   4
`define ASQ_CONV_PERIOD_NS  40
`define ASQ_CONV_HALF_CYC   ((`ASQ_CONV_PERIOD_NS / 2) / `ASQ_CLK_PERIOD_NS)
`define ASQ_TRIG_DELAY_HALF 5
`define ASQ_LAT_A_CC        4
`define ASQ_LAT_B_CC        5
`define ASQ_GAP_SIM_CC      2
`define ASQ_GAP_SEQ_CC      1
`define ASQ_IRQ_LAG         2
`define ASQ_CODE_W          12

// Register byte offsets.
`define ASQ_OFF_CTRL   8'h00
`define ASQ_OFF_SWTRIG 8'h04
`define ASQ_OFF_STATUS 8'h08
`define ASQ_OFF_MASK   8'h0c
`define ASQ_OFF_RES_A  8'h10
`define ASQ_OFF_RES_B  8'h14

// Control fields.
`define ASQ_CTRL_SAMP_ARR 0
`define ASQ_CTRL_CHAN_LO 1
`define ASQ_CTRL_ACQ_LO  8
`define ASQ_CTRL_CONT    16
`define ASQ_CTRL_PWM_EN  17
`define ASQ_CTRL_EXT_EN  18
`define ASQ_CTRL_WMASK   32'h0007_0f1f
`define ASQ_CTRL_RESET   32'h0000_0000

// Status and mask fields.
`define ASQ_ST_A       0
`define ASQ_ST_B       1
`define ASQ_ST_BUSY    8
`define ASQ_MASK_RESET 2'h0

`endif

//--- hdl/asq_pkg.sv
// Types shared by the sequencer modules.
package asq_pkg;

  typedef enum logic [3:0] {
    ASQ_IDLE  = 4'h1,
    ASQ_DELAY = 4'h2,
    ASQ_HOLD  = 4'h4,
    ASQ_GAP   = 4'h8
  } asq_state_e;

  typedef logic [11:0] asq_code_t;

endpackage : asq_pkg

//--- hdl/asq_pipe_if.sv
// Connection between the sequencer and one conversion pipeline.
interface asq_pipe_if #(parameter int WIDTH = 12);
  logic             adv;
  logic             load;
  logic [WIDTH-1:0] din;
  logic [WIDTH-1:0] dout;
  logic             vld;
  logic             busy;

  modport feed (output adv, output load, output din, input dout, input vld, input busy);
  modport pipe (input adv, input load, input din, output dout, output vld, output busy);
endinterface : asq_pipe_if

//--- hdl/asq_pipe.sv
// Conversion pipeline that delivers a captured code a fixed number of half converter clocks later.
module asq_pipe #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Sequencer side.
  asq_pipe_if.pipe  pif
);

  logic [WIDTH-1:0] data_r   [DEPTH];
  logic [WIDTH-1:0] data_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;

  // Stages advance only on the half-clock enable, so latency is counted in converter time.
  always_comb
  begin
    data_nxt = data_r;
    vld_nxt  = vld_r;
    if (pif.adv)
    begin
      data_nxt[0] = pif.din;
      vld_nxt[0]  = pif.load;
      for (int i = 1; i < DEPTH; i++)
      begin
        data_nxt[i] = data_r[i-1];
        vld_nxt[i]  = vld_r[i-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        data_r[i] <= '0;
      end
    end
    else
    begin
      vld_r  <= vld_nxt;
      data_r <= data_nxt;
    end
  end

  assign pif.dout = data_r[DEPTH-1];
  assign pif.vld  = pif.adv & vld_r[DEPTH-1];
  assign pif.busy = |vld_r;

endmodule : asq_pipe

//--- hdl/asq_top.sv
// Sample/hold sequencer with APB registers, two conversion pipelines and an interrupt.
`include "asq_defines.svh"

module asq_top #(
  parameter int CONV_HALF = `ASQ_CONV_HALF_CYC,
  parameter int IRQ_LAG   = `ASQ_IRQ_LAG
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Start sources.
  input  wire logic        pwm_event_source,
  input  wire logic        external_convert_start,
  // Analog front end.
  input  wire logic [11:0] samp_a_code,
  input  wire logic [11:0] samp_b_code,
  output logic             sh_pulse,
  output logic [3:0]       chan_a_sel,
  output logic [3:0]       chan_b_sel,
  output logic             converter_clock,
  // Interrupt.
  output logic             irq
);

  localparam int DIVW = 4;
  localparam logic [DIVW-1:0] HALF_LAST = DIVW'(CONV_HALF - 1);
  localparam logic [5:0] DELAY_LAST = 6'(`ASQ_TRIG_DELAY_HALF - 1);
  localparam logic [5:0] GAP_SIM_LAST = 6'(2 * `ASQ_GAP_SIM_CC - 1);
  localparam logic [5:0] GAP_SEQ_LAST = 6'(2 * `ASQ_GAP_SEQ_CC - 1);

  // APB decode.
  logic wr_en;
  logic rd_setup;
  logic rd_access;
  logic addr_hit;

  // Registers seen by software.
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [1:0]  mask_r;
  logic [1:0]  mask_nxt;
  logic [1:0]  st_r;
  logic [1:0]  st_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  asq_pkg::asq_code_t res_a_r;
  asq_pkg::asq_code_t res_a_nxt;
  asq_pkg::asq_code_t res_b_r;
  asq_pkg::asq_code_t res_b_nxt;

  // Control fields.
  logic       sampling_arrangement_bit;
  logic [3:0] chan;
  logic [3:0] acq;
  logic       cont;

  // Converter clock divider.
  logic [DIVW-1:0] div_r;
  logic [DIVW-1:0] div_nxt;
  logic            cclk_r;
  logic            cclk_nxt;
  logic            half_tick;

  // Start synchronisers.
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_rise;
  logic sw_trig;
  logic trig_any;
  logic trig_go;

  // Front end codes pass two flops before capture.
  asq_pkg::asq_code_t a_meta_r;
  asq_pkg::asq_code_t a_sync_r;
  asq_pkg::asq_code_t b_meta_r;
  asq_pkg::asq_code_t b_sync_r;

  // Sequencer.
  asq_pkg::asq_state_e state_r;
  asq_pkg::asq_state_e state_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       sh_r;
  logic       sh_nxt;
  logic       capture;
  logic [5:0] hold_last;
  logic [5:0] gap_last;

  // Interrupt lag lines.
  logic [IRQ_LAG-1:0] lag_a_r;
  logic [IRQ_LAG-1:0] lag_a_nxt;
  logic [IRQ_LAG-1:0] lag_b_r;
  logic [IRQ_LAG-1:0] lag_b_nxt;
  logic [1:0]         st_set;
  logic [1:0]         st_clr;

  asq_pipe_if #(.WIDTH(`ASQ_CODE_W)) pa_if ();
  asq_pipe_if #(.WIDTH(`ASQ_CODE_W)) pb_if ();

  assign sampling_arrangement_bit = ctrl_r[`ASQ_CTRL_SAMP_ARR];
  assign chan  = ctrl_r[`ASQ_CTRL_CHAN_LO +: 4];
  assign acq   = ctrl_r[`ASQ_CTRL_ACQ_LO +: 4];
  assign cont  = ctrl_r[`ASQ_CTRL_CONT];

  assign wr_en     = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;
  assign rd_access = psel & penable & ~pwrite;

  always_comb
  begin
    unique case (paddr)
      `ASQ_OFF_CTRL,
      `ASQ_OFF_SWTRIG,
      `ASQ_OFF_STATUS,
      `ASQ_OFF_MASK,
      `ASQ_OFF_RES_A,
      `ASQ_OFF_RES_B: addr_hit = 1'b1;
      default:        addr_hit = 1'b0;
    endcase
  end

  // Converter clock divider; restarting it on a trigger fixes the phase of the start delay.
  assign half_tick = (div_r == HALF_LAST);

  always_comb
  begin
    div_nxt  = div_r + DIVW'(1);
    cclk_nxt = cclk_r;
    if (trig_go)
    begin
      div_nxt  = '0;
      cclk_nxt = 1'b0;
    end
    else if (half_tick)
    begin
      div_nxt  = '0;
      cclk_nxt = ~cclk_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r  <= '0;
      cclk_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_nxt;
      cclk_r <= cclk_nxt;
    end
  end

  // Start sources; the pin is synchronised and edge detected on the second flop only.
  assign ext_rise = ext_sync_r & ~ext_prev_r;
  assign sw_trig  = wr_en & (paddr == `ASQ_OFF_SWTRIG) & pwdata[0];
  assign trig_any = sw_trig | (ctrl_r[`ASQ_CTRL_PWM_EN] & pwm_event_source) |
                    (ctrl_r[`ASQ_CTRL_EXT_EN] & ext_rise);
  // A start while results are still in flight would shift their latency, so it is dropped.
  assign trig_go  = trig_any & (state_r == asq_pkg::ASQ_IDLE) & ~pa_if.busy & ~pb_if.busy;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
      a_meta_r   <= '0;
      a_sync_r   <= '0;
      b_meta_r   <= '0;
      b_sync_r   <= '0;
    end
    else
    begin
      ext_meta_r <= external_convert_start;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      a_meta_r   <= samp_a_code;
      a_sync_r   <= a_meta_r;
      b_meta_r   <= samp_b_code;
      b_sync_r   <= b_meta_r;
    end
  end

  // Counts run in half converter clocks so that the two-and-a-half clock delay is exact.
  assign hold_last = {1'b0, acq, 1'b1};
  assign gap_last  = sampling_arrangement_bit ? GAP_SIM_LAST : GAP_SEQ_LAST;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    capture   = 1'b0;
    unique case (state_r)
      asq_pkg::ASQ_IDLE:
      begin
        if (trig_go)
        begin
          state_nxt = asq_pkg::ASQ_DELAY;
          cnt_nxt   = DELAY_LAST;
        end
      end
      asq_pkg::ASQ_DELAY:
      begin
        if (half_tick)
        begin
          if (cnt_r == 6'h00)
          begin
            state_nxt = asq_pkg::ASQ_HOLD;
            cnt_nxt   = hold_last;
          end
          else
          begin
            cnt_nxt = cnt_r - 6'h01;
          end
        end
      end
      asq_pkg::ASQ_HOLD:
      begin
        if (half_tick)
        begin
          if (cnt_r == 6'h00)
          begin
            capture   = 1'b1;
            state_nxt = asq_pkg::ASQ_GAP;
            cnt_nxt   = gap_last;
          end
          else
          begin
            cnt_nxt = cnt_r - 6'h01;
          end
        end
      end
      asq_pkg::ASQ_GAP:
      begin
        if (half_tick)
        begin
          if (cnt_r == 6'h00)
          begin
            // Clearing the continuous bit ends the run after the pulse in progress.
            state_nxt = cont ? asq_pkg::ASQ_HOLD : asq_pkg::ASQ_IDLE;
            cnt_nxt   = hold_last;
          end
          else
          begin
            cnt_nxt = cnt_r - 6'h01;
          end
        end
      end
      default:
      begin
        state_nxt = asq_pkg::ASQ_IDLE;
        cnt_nxt   = 6'h00;
      end
    endcase
    sh_nxt = (state_nxt == asq_pkg::ASQ_HOLD);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= asq_pkg::ASQ_IDLE;
      cnt_r   <= 6'h00;
      sh_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
    end
  end

  // Pipelines: group A always converts, group B only in simultaneous mode.
  assign pa_if.adv  = half_tick;
  assign pa_if.load = capture;
  assign pa_if.din  = a_sync_r;
  assign pb_if.adv  = half_tick;
  assign pb_if.load = capture & sampling_arrangement_bit;
  assign pb_if.din  = b_sync_r;

  asq_pipe #(.WIDTH(`ASQ_CODE_W), .DEPTH(2 * `ASQ_LAT_A_CC)) u_pipe_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pif     (pa_if.pipe)
  );

  asq_pipe #(.WIDTH(`ASQ_CODE_W), .DEPTH(2 * `ASQ_LAT_B_CC)) u_pipe_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pif     (pb_if.pipe)
  );

  // Results and interrupt flags; each flag trails its result write by a fixed lag.
  assign st_set = {lag_b_r[IRQ_LAG-1], lag_a_r[IRQ_LAG-1]};
  // Only the flags latched for the reader are cleared, so one set after the setup cycle is not lost.
  assign st_clr = {2{rd_access & (paddr == `ASQ_OFF_STATUS)}} & prdata_r[1:0];

  always_comb
  begin
    res_a_nxt = pa_if.vld ? pa_if.dout : res_a_r;
    res_b_nxt = pb_if.vld ? pb_if.dout : res_b_r;
    lag_a_nxt = IRQ_LAG'({lag_a_r, pa_if.vld});
    lag_b_nxt = IRQ_LAG'({lag_b_r, pb_if.vld});
    // A flag set in the same cycle as a clearing read survives.
    st_nxt    = (st_r & ~st_clr) | st_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_a_r <= '0;
      res_b_r <= '0;
      lag_a_r <= '0;
      lag_b_r <= '0;
      st_r    <= 2'h0;
    end
    else
    begin
      res_a_r <= res_a_nxt;
      res_b_r <= res_b_nxt;
      lag_a_r <= lag_a_nxt;
      lag_b_r <= lag_b_nxt;
      st_r    <= st_nxt;
    end
  end

  // Software registers; read data is latched in the setup cycle, which keeps pready high.
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    mask_nxt   = mask_r;
    prdata_nxt = prdata_r;
    if (wr_en && paddr == `ASQ_OFF_CTRL)
    begin
      ctrl_nxt = pwdata & `ASQ_CTRL_WMASK;
    end
    if (wr_en && paddr == `ASQ_OFF_MASK)
    begin
      mask_nxt = pwdata[1:0];
    end
    if (rd_setup)
    begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        `ASQ_OFF_CTRL:   prdata_nxt = ctrl_r;
        `ASQ_OFF_STATUS:
        begin
          prdata_nxt[1:0]          = st_r;
          prdata_nxt[`ASQ_ST_BUSY] = (state_r != asq_pkg::ASQ_IDLE) | pa_if.busy | pb_if.busy;
        end
        `ASQ_OFF_MASK:   prdata_nxt[1:0] = mask_r;
        `ASQ_OFF_RES_A:  prdata_nxt[11:0] = res_a_r;
        `ASQ_OFF_RES_B:  prdata_nxt[11:0] = res_b_r;
        default:         prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r   <= `ASQ_CTRL_RESET;
      mask_r   <= `ASQ_MASK_RESET;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      mask_r   <= mask_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Outputs.
  assign prdata          = prdata_r;
  assign pready          = 1'b1;
  assign pslverr         = psel & penable & ~addr_hit;
  assign sh_pulse        = sh_r;
  assign converter_clock = cclk_r;
  // In simultaneous mode the pair index is the low three bits; group B shares it.
  assign chan_a_sel      = sampling_arrangement_bit ? {1'b0, chan[2:0]} : chan;
  assign chan_b_sel      = {1'b0, chan[2:0]};
  assign irq             = |(st_r & mask_r);

endmodule : asq_top

//--- dv/asq_src.sv
// Model of the start sources outside the block: the PWM event line and the external start pin.
module asq_src (
  // Clock.
  input  wire logic pclk,
  // Commands from the bench.
  input  wire logic pwm_go,
  input  wire logic ext_go,
  // Start lines.
  output logic      pwm_event_source = 1'b0,
  output logic      external_convert_start = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pwm_q = 1'b0;
  // The event is one cycle wide however long the bench holds its command.
  always @(posedge pclk)
  begin
    pwm_q <= pwm_go;
    pwm_event_source <= pwm_go && !pwm_q;
    external_convert_start <= ext_go;
  end
endmodule : asq_src

//--- dv/asq_assertions.sv
// Port-level assertions for the simultaneous-sample sequencer.
module asq_chk #(
  parameter int CONV_HALF = 5,
  parameter int IRQ_LAG   = 2
) (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Start sources, front end and interrupt.
  input wire logic        pwm_event_source,
  input wire logic        external_convert_start,
  input wire logic [11:0] samp_a_code,
  input wire logic [11:0] samp_b_code,
  input wire logic        sh_pulse,
  input wire logic [3:0]  chan_a_sel,
  input wire logic [3:0]  chan_b_sel,
  input wire logic        converter_clock,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic [7:0]  hi_r, hi_nxt, fall_r, fall_nxt;
  logic        sh_r, wr, mwr, go, mapped, quiet;
  assign wr = psel && penable && pwrite;
  assign mwr = wr && paddr == 8'h0c;
  assign go = wr && paddr == 8'h04 && pwdata[0];
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  // Triggers are judged only once the pipelines have drained, since earlier ones may be dropped.
  assign quiet = !sh_pulse && fall_r >= 8'h3c;
  always_comb
  begin
    ctrl_nxt = (wr && paddr == 8'h00) ? (pwdata & 32'h0007_0f1f) : ctrl_r;
    mask_nxt = mwr ? pwdata[1:0] : mask_r;
    hi_nxt = sh_pulse ? hi_r + 8'h01 : 8'h00;
    fall_nxt = (sh_r && !sh_pulse) ? 8'h01 : fall_r + {7'h0, fall_r != 8'hff};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= 32'h0;
      mask_r <= 2'h0;
      hi_r <= 8'h00;
      fall_r <= 8'hff;
      sh_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      hi_r <= hi_nxt;
      fall_r <= fall_nxt;
      sh_r <= sh_pulse;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_late_rise;
    !sh_pulse ##23 !sh_pulse ##[1:3] sh_pulse;
  endsequence
  property p_start;
    (go || (pwm_event_source && ctrl_r[17])) && quiet |-> s_late_rise;
  endproperty
  a_start: assert property (p_start) else $error("sample pulse not on time after trigger");
  property p_width;
    $fell(sh_pulse) |-> int'(hi_r) == 2 * CONV_HALF * (1 + int'(ctrl_r[11:8]));
  endproperty
  a_width: assert property (p_width) else $error("sample pulse width wrong");
  property p_gap;
    $rose(sh_pulse) && fall_r < 8'h3c |-> int'(fall_r) == (ctrl_r[0] ? 4 : 2) * CONV_HALF;
  endproperty
  a_gap: assert property (p_gap) else $error("continuous sample spacing wrong");
  property p_irq;
    $rose(irq) && !$past(mwr) && !ctrl_r[16] |->
      int'(fall_r) inside {8 * CONV_HALF + IRQ_LAG, 10 * CONV_HALF + IRQ_LAG};
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not at result latency plus lag");
  property p_mask;
    irq |-> mask_r != 2'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt high with all sources masked");
  property p_pair;
    ctrl_r[0] |-> chan_a_sel == {1'b0, ctrl_r[3:1]} && chan_b_sel == chan_a_sel;
  endproperty
  a_pair: assert property (p_pair) else $error("pair selection wrong");
  property p_single;
    !ctrl_r[0] |-> chan_a_sel == ctrl_r[4:1];
  endproperty
  a_single: assert property (p_single) else $error("single channel selection wrong");
  property p_apb;
    psel && penable |-> pready && pslverr == !mapped;
  endproperty
  a_apb: assert property (p_apb) else $error("bus response wrong");
  // A rise of the converter clock follows a full low half period.
  property p_cclk;
    $rose(converter_clock) |-> !$past(converter_clock, 2) && !$past(converter_clock, 3) &&
      !$past(converter_clock, 4) && !$past(converter_clock, 5);
  endproperty
  a_cclk: assert property (p_cclk) else $error("converter clock low phase too short");
endmodule : asq_chk

bind asq_top asq_chk #(.CONV_HALF(CONV_HALF), .IRQ_LAG(IRQ_LAG)) asq_chk_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_event_source, .external_convert_start, .samp_a_code,
  .samp_b_code, .sh_pulse, .chan_a_sel, .chan_b_sel, .converter_clock, .irq);

//--- dv/tb_top.sv
// Self-checking bench for the simultaneous-sample sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 5;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdq;
  logic        pready, pslverr, sh_pulse, converter_clock, irq, pwm_event_source, external_convert_start;
  logic        pwm_go = 1'b0, ext_go = 1'b0, slv;
  logic [11:0] samp_a = 12'h000, samp_b = 12'h000;
  logic [3:0]  chan_a_sel, chan_b_sel;
  int          err_total = 0, num_checks = 0;
  always #2 pclk = ~pclk;
  asq_top #(.CONV_HALF(CH), .IRQ_LAG(2)) asq_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pwm_event_source, .external_convert_start, .samp_a_code(samp_a),
    .samp_b_code(samp_b), .sh_pulse, .chan_a_sel, .chan_b_sel, .converter_clock, .irq);
  asq_src asq_src_inst (.pclk, .pwm_go, .ext_go, .pwm_event_source, .external_convert_start);

  task automatic final_report();
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic fail();
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    final_report();
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      fail();
    rdq = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Levels are sampled on the falling edge so registered outputs have settled.
  task automatic wt(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (s !== v && n < lim);
    if (s !== v)
      fail();
    @(posedge pclk);
  endtask : wt

  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk(rdq, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdq, 32'h0);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdq, 32'h0007_0f1f);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h20, 32'h5);
    apb(1'b0, 8'h20, 32'h0);
    chk({rdq[31:1], slv}, 32'h1);
  endtask : t_regs

  // The codes change right after the falling edge, so a late capture shows up as a wrong result.
  task automatic t_pair(input logic [2:0] p);
    logic [3:0] acq;
    acq = (p == 3'h7) ? 4'hf : {p, 1'b0};
    samp_a <= {9'h080, p};
    samp_b <= {9'h160, p};
    apb(1'b1, 8'h0c, 32'h3);
    apb(1'b1, 8'h00, {20'h0, acq, 4'h0, p, 1'b1});
    apb(1'b1, 8'h04, 32'h1);
    wt(sh_pulse, 1'b1, 40);
    wt(sh_pulse, 1'b0, 200);
    samp_a <= ~samp_a;
    samp_b <= ~samp_b;
    wt(irq, 1'b1, 80);
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk(rdq, {20'h0, 9'h080, p});
    apb(1'b0, 8'h14, 32'h0);
    chk(rdq, {20'h0, 9'h160, p});
    apb(1'b0, 8'h08, 32'h0);
    chk(rdq, 32'h3);
    apb(1'b0, 8'h08, 32'h0);
    chk(rdq, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_pair

  task automatic t_src(input logic ext);
    apb(1'b1, 8'h0c, {30'h0, ext, ext});
    apb(1'b1, 8'h00, ext ? 32'h0004_0001 : 32'h0002_0012);
    samp_a <= 12'h5a5;
    pwm_go <= !ext;
    ext_go <= ext;
    repeat (3) @(posedge pclk);
    pwm_go <= 1'b0;
    ext_go <= 1'b0;
    wt(sh_pulse, 1'b1, 60);
    wt(sh_pulse, 1'b0, 40);
    repeat (70) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, ext});
    apb(1'b0, 8'h08, 32'h0);
    chk(rdq, ext ? 32'h3 : 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rdq, 32'h0000_05a5);
  endtask : t_src

  // Runs continuous conversion in simultaneous or sequential arrangement.
  task automatic t_cont(input logic sim);
    apb(1'b1, 8'h00, {31'h0000_8080, sim});
    apb(1'b1, 8'h04, 32'h1);
    repeat (4)
    begin
      wt(sh_pulse, 1'b1, 60);
      wt(sh_pulse, 1'b0, 40);
    end
    apb(1'b1, 8'h00, {31'h0000_0080, sim});
    repeat (120) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk(rdq, sim ? 32'h3 : 32'h1);
  endtask : t_cont

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    for (int i = 0; i < 8; i++)
      t_pair(3'(i));
    t_src(1'b0);
    t_src(1'b1);
    t_cont(1'b1);
    t_cont(1'b0);
    final_report();
  end
endmodule : tb_top
